/* File: nvm_pkg.sv */
package nvm_pkg;

    localparam int ADDR_W = 15;
    localparam int MEM_DEPTH = 32768;

    localparam logic [7:0] OP_SET_LATCH    = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;

    localparam logic [14:0] QUARTER_BASE = 15'h6000;
    localparam logic [14:0] HALF_BASE    = 15'h4000;
    localparam logic [14:0] ADDR_TOP     = 15'h7FFF;
    localparam logic [14:0] ADDR_ZERO    = 15'h0000;
    localparam logic [14:0] ADDR_STEP    = 15'h0001;

    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;
    localparam logic [1:0] BP_ALL     = 2'h3;

    // Nonvolatile status bits 7..2 are kept as a six-bit field.
    localparam int NV_PROTECT_EN = 5;
    localparam int NV_BP_HI      = 1;
    localparam int NV_BP_LO      = 0;
    localparam logic [5:0] NV_RESET = 6'h00;
    localparam logic       BIT0_VAL = 1'b0;

    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [3:0] ADDR_LAST = 4'hF;
    localparam logic [3:0] CNT_ZERO  = 4'h0;
    localparam logic [3:0] CNT_STEP  = 4'h1;

    typedef enum logic [2:0] {
        ST_OPC  = 3'b000,
        ST_ADDR = 3'b001,
        ST_RD   = 3'b010,
        ST_WR   = 3'b011,
        ST_SRD  = 3'b100,
        ST_SWR  = 3'b101,
        ST_IGN  = 3'b110
    } state_t;

    function automatic logic is_protected(input logic [1:0]  bp,
                                          input logic [14:0] a);
        case (bp)
            BP_QUARTER: return a >= QUARTER_BASE;
            BP_HALF:    return a >= HALF_BASE;
            BP_ALL:     return 1'b1;
            default:    return 1'b0;
        endcase
    endfunction

endpackage

/* File: spi_link_if.sv */
`timescale 1ns/1ps
interface spi_link_if;
    logic sel;
    logic desel;
    logic rise;
    logic fall;
    logic si_bit;
    logic held;
    logic wp_lvl;

    modport front (
        output sel,
        output desel,
        output rise,
        output fall,
        output si_bit,
        output held,
        output wp_lvl
    );

    modport core (
        input sel,
        input desel,
        input rise,
        input fall,
        input si_bit,
        input held,
        input wp_lvl
    );
endinterface

/* File: nv_pin_front.sv */
`timescale 1ns/1ps
module nv_pin_front
    import nvm_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  wire logic   cs_n,
    input  wire logic   sck,
    input  wire logic   si,
    input  wire logic   hold_n,
    input  wire logic   wp_n,
    spi_link_if.front   lk
);

    // Pin order in the sync vectors: cs_n, sck, si, hold_n, wp_n.
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic       sck_d;
        logic       cs_d;
        logic       held;
    } front_t;

    front_t r_r;
    front_t r_nxt;

    logic cs_s;
    logic sck_s;
    logic si_s;
    logic hold_s;
    logic wp_s;

    assign {cs_s, sck_s, si_s, hold_s, wp_s} = r_r.s2;

    always_comb
    begin
        r_nxt       = r_r;
        r_nxt.s1    = {cs_n, sck, si, hold_n, wp_n};
        r_nxt.s2    = r_r.s1;
        r_nxt.sck_d = sck_s;
        r_nxt.cs_d  = cs_s;
        // Hold only changes while the clock is low or the device is deselected,
        // so a hold edge seen with the clock high waits for the next low phase.
        if (cs_s)
            r_nxt.held = 1'b0;
        else if (!sck_s)
            r_nxt.held = !hold_s;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            r_r <= '{s1: 5'h1F, s2: 5'h1F, sck_d: 1'b0, cs_d: 1'b1,
                     held: 1'b0};
        else
            r_r <= r_nxt;
    end

    assign lk.sel    = !cs_s;
    assign lk.desel  = cs_s && !r_r.cs_d;
    assign lk.rise   = !cs_s && !r_r.held && sck_s && !r_r.sck_d;
    assign lk.fall   = !cs_s && !r_r.held && !sck_s && r_r.sck_d;
    assign lk.si_bit = si_s;
    assign lk.held   = r_r.held;
    assign lk.wp_lvl = wp_s;

endmodule // nv_pin_front

/* File: nv_spi_memory.sv */
`timescale 1ns/1ps
module nv_spi_memory
    import nvm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so,
    output logic      so_oe,
    output logic      write_enable_latch,
    output logic      status_protect_enable,
    output logic      block_protect_hi,
    output logic      block_protect_lo
);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    typedef struct packed {
        state_t      st;
        logic [3:0]  cnt;
        logic [15:0] sh;
        logic [14:0] addr;
        logic        is_wr;
        logic        latch;
        logic [5:0]  nv;
        logic [7:0]  osh;
        logic        so;
        logic        oe;
    } core_t;

    spi_link_if lk ();

    nv_pin_front u_front (
        .sys_clk (sys_clk),
        .rst     (rst),
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si),
        .hold_n  (hold_n),
        .wp_n    (wp_n),
        .lk      (lk)
    );

    logic [7:0]  mem [MEM_DEPTH];
    core_t       r_r;
    core_t       r_nxt;
    logic [15:0] sh_in;
    logic [7:0]  byte_in;
    logic [7:0]  status;
    logic [14:0] addr_inc;
    logic        byte_end;
    logic        mem_we;
    logic        sr_locked;
    logic [1:0]  bp;

    assign sh_in    = {r_r.sh[14:0], lk.si_bit};
    assign byte_in  = sh_in[7:0];
    assign status   = {r_r.nv, r_r.latch, BIT0_VAL};
    assign addr_inc = r_r.addr + ADDR_STEP;
    assign byte_end = lk.rise && (r_r.cnt[2:0] == BIT_LAST);
    assign bp       = {r_r.nv[NV_BP_HI], r_r.nv[NV_BP_LO]};
    assign sr_locked = !r_r.latch
                     || (r_r.nv[NV_PROTECT_EN] && !lk.wp_lvl);

    always_comb
    begin
        r_nxt  = r_r;
        mem_we = 1'b0;
        if (lk.desel)
        begin
            // Write commands drop the latch once the frame ends.
            if (r_r.is_wr)
                r_nxt.latch = 1'b0;
            r_nxt.st    = ST_OPC;
            r_nxt.cnt   = CNT_ZERO;
            r_nxt.is_wr = 1'b0;
            r_nxt.oe    = 1'b0;
        end
        else if (lk.rise)
        begin
            r_nxt.sh  = sh_in;
            r_nxt.cnt = r_r.cnt + CNT_STEP;
            case (r_r.st)
                ST_OPC:
                begin
                    if (byte_end)
                    begin
                        r_nxt.cnt = CNT_ZERO;
                        r_nxt.st  = ST_IGN;
                        case (byte_in)
                            OP_SET_LATCH:
                                r_nxt.latch = 1'b1;
                            OP_CLEAR_LATCH:
                                r_nxt.latch = 1'b0;
                            OP_STATUS_READ:
                            begin
                                r_nxt.st  = ST_SRD;
                                r_nxt.osh = status;
                            end
                            OP_STATUS_WRITE:
                            begin
                                r_nxt.st    = ST_SWR;
                                r_nxt.is_wr = 1'b1;
                            end
                            OP_ARRAY_READ:
                                r_nxt.st = ST_ADDR;
                            OP_ARRAY_WRITE:
                            begin
                                r_nxt.st    = ST_ADDR;
                                r_nxt.is_wr = 1'b1;
                            end
                            default:
                                r_nxt.st = ST_IGN;
                        endcase
                    end
                end
                ST_ADDR:
                begin
                    if (r_r.cnt == ADDR_LAST)
                    begin
                        // Bit 15 of the address is shifted in and dropped.
                        r_nxt.addr = sh_in[14:0];
                        r_nxt.cnt  = CNT_ZERO;
                        if (r_r.is_wr)
                            r_nxt.st = ST_WR;
                        else
                        begin
                            r_nxt.st  = ST_RD;
                            r_nxt.osh = mem[sh_in[14:0]];
                        end
                    end
                end
                ST_RD:
                begin
                    if (byte_end)
                    begin
                        r_nxt.cnt  = CNT_ZERO;
                        r_nxt.addr = addr_inc;
                        r_nxt.osh  = mem[addr_inc];
                    end
                end
                ST_WR:
                begin
                    if (byte_end)
                    begin
                        r_nxt.cnt  = CNT_ZERO;
                        r_nxt.addr = addr_inc;
                        mem_we = r_r.latch
                              && !is_protected(bp, r_r.addr);
                    end
                end
                ST_SRD:
                begin
                    if (byte_end)
                    begin
                        r_nxt.cnt = CNT_ZERO;
                        r_nxt.osh = status;
                    end
                end
                ST_SWR:
                begin
                    if (byte_end)
                    begin
                        r_nxt.cnt = CNT_ZERO;
                        r_nxt.st  = ST_IGN;
                        if (!sr_locked)
                            r_nxt.nv = byte_in[7:2];
                    end
                end
                default:
                    r_nxt.cnt = CNT_ZERO;
            endcase
        end
        else if (lk.fall && (r_r.st == ST_RD || r_r.st == ST_SRD))
        begin
            // Mode 3 also gives a falling edge before the opcode; it lands
            // in the opcode state and is ignored there.
            r_nxt.so  = r_r.osh[7];
            r_nxt.osh = {r_r.osh[6:0], 1'b0};
            r_nxt.oe  = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            r_r <= '{st: ST_OPC, cnt: CNT_ZERO, sh: 16'h0000,
                     addr: ADDR_ZERO, is_wr: 1'b0, latch: 1'b0,
                     nv: NV_RESET, osh: 8'h00, so: 1'b0, oe: 1'b0};
        else
            r_r <= r_nxt;
    end

    // The array has no reset: its contents model nonvolatile cells.
    always_ff @(posedge sys_clk)
    begin
        if (mem_we)
            mem[r_r.addr] <= byte_in;
    end

    assign so    = r_r.so;
    assign so_oe = r_r.oe && lk.sel && !lk.held;
    assign write_enable_latch    = r_r.latch;
    assign status_protect_enable = r_r.nv[NV_PROTECT_EN];
    assign block_protect_hi      = r_r.nv[NV_BP_HI];
    assign block_protect_lo      = r_r.nv[NV_BP_LO];

    logic opc_done;
    assign opc_done = byte_end && r_r.st == ST_OPC;

    a_desel_idle: assert property (
        lk.desel |=> (r_r.st == ST_OPC && r_r.cnt == CNT_ZERO && !so_oe))
        else $error("deselect did not return to opcode wait");

    a_idle_float: assert property (
        !lk.sel && !lk.desel |-> !r_r.oe)
        else $error("output enabled while deselected");

    a_hold_float: assert property (
        lk.held |-> !so_oe)
        else $error("output driven during hold");

    a_latch_set: assert property (
        opc_done && byte_in == OP_SET_LATCH |=> r_r.latch)
        else $error("latch set command did not set latch");

    a_latch_clear: assert property (
        opc_done && byte_in == OP_CLEAR_LATCH |=> !r_r.latch)
        else $error("latch clear command did not clear latch");

    a_write_guard: assert property (
        mem_we |-> r_r.st == ST_WR && r_r.latch
                   && r_r.cnt[2:0] == BIT_LAST)
        else $error("array write outside an enabled byte end");

    a_read_wrap: assert property (
        r_r.st == ST_RD && byte_end && r_r.addr == ADDR_TOP
        |=> r_r.addr == ADDR_ZERO)
        else $error("read address did not wrap");

    a_write_wrap: assert property (
        r_r.st == ST_WR && byte_end && r_r.addr == ADDR_TOP
        |=> r_r.addr == ADDR_ZERO)
        else $error("write address did not wrap");

    a_hold_freeze: assert property (
        lk.held && !lk.desel |=> $stable(r_r.sh) && $stable(r_r.cnt))
        else $error("shift state moved during hold");

    a_so_on_fall: assert property (
        $changed(r_r.so) |-> $past(lk.fall))
        else $error("output changed without a falling edge");

    a_status_repeat: assert property (
        r_r.st == ST_SRD && byte_end |=> r_r.osh == $past(status))
        else $error("status byte not reloaded");

    a_status_lock: assert property (
        r_r.st == ST_SWR && byte_end && sr_locked |=> $stable(r_r.nv))
        else $error("locked status register was written");

    c_status_read: cover property (
        r_r.st == ST_SRD && lk.fall ##1 r_r.oe);
    c_array_write: cover property (mem_we);
    c_hold_read: cover property (r_r.st == ST_RD && lk.held);
    c_write_wrap: cover property (
        r_r.st == ST_WR && byte_end && r_r.addr == ADDR_TOP);

endmodule // nv_spi_memory

/* File: spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic sys_clk,
    input  wire logic so,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    logic cpol_r;

    initial
    begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b1;
        hold_n = 1'b1;
        cpol_r = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // The idle level of the clock at select time fixes the mode.
    task automatic open_frame(input logic cpol);
        @(posedge sys_clk);
        cpol_r = cpol;
        sck <= cpol;
        wait_clk(8);
        cs_n <= 1'b0;
        wait_clk(7);
    endtask

    // Phases of 8 and 6 cycles give a link period of 70 ns.
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            sck <= 1'b0;
            si  <= tx[7 - i];
            wait_clk(7);
            @(negedge sys_clk);
            // A floating output reads back inverted so a lost enable shows.
            rx = {rx[6:0], so_oe ? so : ~so};
            @(posedge sys_clk);
            sck <= 1'b1;
            wait_clk(6);
        end
    endtask

    // A released data line toggles so a stale bit is never reused.
    task automatic close_frame();
        sck <= cpol_r;
        wait_clk(7);
        cs_n <= 1'b1;
        si   <= ~si;
        wait_clk(10);
    endtask

    task automatic hold_begin();
        sck <= 1'b0;
        wait_clk(7);
        hold_n <= 1'b0;
        wait_clk(8);
    endtask

    // Clock and data wiggle while held; the device must ignore both.
    task automatic hold_end();
        sck <= 1'b1;
        si  <= ~si;
        wait_clk(7);
        sck <= 1'b0;
        si  <= ~si;
        wait_clk(7);
        hold_n <= 1'b1;
        wait_clk(7);
    endtask
endmodule // spi_host_model

/* File: nv_spi_memory_tb.sv */
`timescale 1ns/1ps
module nv_spi_memory_tb
    import nvm_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        wp_n = 1'b1;
    logic        cs_n, sck, si, hold_n, so, so_oe;
    logic        write_enable_latch, status_protect_enable;
    logic        block_protect_hi, block_protect_lo;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc_cnt = 0;
    logic [15:0] pa [4] = '{16'h3FFF, 16'h4000, 16'h5FFF, 16'h6000};
    logic [7:0]  pe [4];

    always #2.5 sys_clk = ~sys_clk;

    nv_spi_memory nv_spi_memory_i (
        .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
        .write_enable_latch(write_enable_latch),
        .status_protect_enable(status_protect_enable),
        .block_protect_hi(block_protect_hi),
        .block_protect_lo(block_protect_lo));

    spi_host_model spi_host_model_i (
        .sys_clk(sys_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n),
        .sck(sck), .si(si), .hold_n(hold_n));

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 90000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic frame(input logic cpol, input logic [7:0] op,
                         input logic [15:0] addr, input int nd,
                         input logic [7:0] d0, output logic [7:0] r0,
                         output logic [7:0] r1);
        logic [7:0] junk;
        spi_host_model_i.open_frame(cpol);
        spi_host_model_i.shift(op, 8, junk);
        if (op == OP_ARRAY_READ || op == OP_ARRAY_WRITE)
        begin
            spi_host_model_i.shift(addr[15:8], 8, junk);
            spi_host_model_i.shift(addr[7:0], 8, junk);
        end
        if (nd > 0)
            spi_host_model_i.shift(d0, 8, r0);
        if (nd > 1)
            spi_host_model_i.shift(~d0, 8, r1);
        spi_host_model_i.close_frame();
    endtask

    task automatic cmd(input logic [7:0] op, input int nd,
                       input logic [15:0] addr, input logic [7:0] d0);
        logic [7:0] r0, r1;
        frame(1'b0, op, addr, nd, d0, r0, r1);
    endtask

    task automatic st_is(input logic [7:0] exp);
        logic [7:0] r0, r1;
        frame(1'b0, OP_STATUS_READ, 16'h0000, 2, 8'hA5, r0, r1);
        check("status", r0, exp);
        check("status again", r1, exp);
    endtask

    task automatic wr_st(input logic [7:0] v);
        cmd(OP_SET_LATCH, 0, 16'h0000, 8'h00);
        cmd(OP_STATUS_WRITE, 1, 16'h0000, v);
    endtask

    task automatic t_latch();
        logic [7:0] junk;
        check("reset latch", {7'h00, write_enable_latch}, 8'h00);
        check("reset output", {7'h00, so_oe}, 8'h00);
        cmd(OP_SET_LATCH, 0, 16'h0000, 8'h00);
        check("latch set", {7'h00, write_enable_latch}, 8'h01);
        st_is(8'h02);
        cmd(OP_CLEAR_LATCH, 0, 16'h0000, 8'h00);
        check("latch clear", {7'h00, write_enable_latch}, 8'h00);
        spi_host_model_i.open_frame(1'b0);
        spi_host_model_i.shift(OP_SET_LATCH, 7, junk);
        spi_host_model_i.close_frame();
        check("partial opcode", {7'h00, write_enable_latch}, 8'h00);
        cmd(OP_SET_LATCH, 0, 16'h0000, 8'h00);
        spi_host_model_i.open_frame(1'b0);
        spi_host_model_i.shift(OP_CLEAR_LATCH, 7, junk);
        spi_host_model_i.close_frame();
        check("partial clear", {7'h00, write_enable_latch}, 8'h01);
        // A reset in mid-run must drop the latch just as power-up does.
        @(posedge sys_clk) rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("mid reset", {7'h00, write_enable_latch}, 8'h00);
    endtask

    task automatic t_status();
        wr_st(8'hFF);
        st_is(8'hFC);
        check("status ports", {5'h00, status_protect_enable,
              block_protect_hi, block_protect_lo}, 8'h07);
        @(posedge sys_clk) wp_n <= 1'b0;
        wr_st(8'h00);
        st_is(8'hFC);
        @(posedge sys_clk) wp_n <= 1'b1;
        wr_st(8'h00);
        st_is(8'h00);
        check("status ports clear", {5'h00, status_protect_enable,
              block_protect_hi, block_protect_lo}, 8'h00);
    endtask

    task automatic t_array();
        logic [7:0] r0, r1;
        cmd(OP_SET_LATCH, 0, 16'h0000, 8'h00);
        cmd(OP_ARRAY_WRITE, 2, 16'hFFFF, 8'h3C);
        check("latch after write", {7'h00, write_enable_latch}, 8'h00);
        frame(1'b1, OP_ARRAY_READ, 16'h7FFF, 2, 8'h5A, r0, r1);
        check("read top", r0, 8'h3C);
        check("read wrapped", r1, 8'hC3);
    endtask

    task automatic t_protect();
        logic [7:0] d, r0, r1;
        logic       prot;
        for (int bp = 0; bp < 4; bp++)
        begin
            wr_st({4'h0, bp[1:0], 2'b00});
            for (int i = 0; i < 4; i++)
            begin
                d = 8'(16 * bp + i + 1);
                prot = bp == 3 || (bp == 2 && pa[i] >= 16'h4000)
                       || (bp == 1 && pa[i] >= 16'h6000);
                if (!prot)
                    pe[i] = d;
                cmd(OP_SET_LATCH, 0, 16'h0000, 8'h00);
                cmd(OP_ARRAY_WRITE, 1, pa[i], d);
            end
            for (int i = 0; i < 4; i++)
            begin
                frame(1'b0, OP_ARRAY_READ, pa[i], 1, 8'hFF, r0, r1);
                check("protect", r0, pe[i]);
            end
        end
        wr_st(8'h00);
        cmd(OP_ARRAY_WRITE, 1, pa[0], 8'hEE);
        frame(1'b0, OP_ARRAY_READ, pa[0], 1, 8'hFF, r0, r1);
        check("write without latch", r0, pe[0]);
    endtask

    // The pause falls mid-byte so a lost bit would shift the byte.
    task automatic t_hold();
        logic [7:0] junk, hi, lo;
        spi_host_model_i.open_frame(1'b0);
        spi_host_model_i.shift(OP_ARRAY_READ, 8, junk);
        spi_host_model_i.shift(pa[0][15:8], 8, junk);
        spi_host_model_i.shift(pa[0][7:0], 8, junk);
        spi_host_model_i.shift(8'h00, 4, hi);
        spi_host_model_i.hold_begin();
        check("held output", {7'h00, so_oe}, 8'h00);
        spi_host_model_i.hold_end();
        spi_host_model_i.shift(8'hFF, 4, lo);
        check("held read", {hi[3:0], lo[3:0]}, pe[0]);
        spi_host_model_i.shift(8'hFF, 8, lo);
        check("read after hold", lo, pe[1]);
        spi_host_model_i.close_frame();
        check("deselect output", {7'h00, so_oe}, 8'h00);
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_latch();
        t_status();
        t_array();
        t_protect();
        t_hold();
        end_sim();
    end
endmodule // nv_spi_memory_tb
